//--- rtl/hmawc_top.sv
// Halt mode sequencer with active halt and timed auto wake-up.
// Assumes the CPU core, timers and interrupt logic share CLK_SYS_IN; the
// wake-up RC oscillator arrives asynchronously on a pin.
//
// Overview of operation
// - Opcode 8E starts halt mode selection.
// - Timer interrupt enables select active halt.
// - Reset exit from active halt waits start-up.
// - Interrupt exit from active halt resumes immediately.
// - Active halt entry clears interrupt mask.
// - Active halt keeps oscillator and timer only.
// - Active halt suppresses watchdog reset on halt.
// - Only realtime or halt-exit interrupts, or reset, end active halt.
// - Wake enable selects auto wake-up halt.
// - RC oscillator, fixed divider, prescaler time wake.
// - Expiry sets wake flag and interrupt.
// - Timed wake restarts oscillator, waits start-up.
// - Status read clears flag; writes ignored.
// - Measure bit routes RC to capture.
// - Wake enable bit is software owned.
// - Auto wake-up halt stops main oscillator.
// - Auto wake-up halt entry clears mask.
// - Watchdog option decides reset on halt.
// - Halt-exit interrupts or reset end halt.
// - Status register resets zero, upper bits zero.
// - Delay is 64 times prescaler plus start.
// - Otherwise halt instruction selects plain halt.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "hmawc_params.svh"

module hmawc_top (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  // Register port
  input wire logic [`HMAWC_ADDR_W-1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  // CPU instruction stream
  input wire logic OPCODE_VALID_IN,
  input wire logic [7:0] OPCODE_IN,
  // Timer configuration
  input wire logic TIMEBASE_IRQ_ENABLE_IN,
  input wire logic OVERFLOW_IRQ_ENABLE_IN,
  input wire logic TIMER_CLOCK_SELECT_HIGH_IN,
  input wire logic TIMER_CLOCK_SELECT_LOW_IN,
  // Watchdog and options
  input wire logic WATCHDOG_ACTIVE_IN,
  input wire logic WATCHDOG_IN_HALT_OPTION_IN,
  input wire logic STARTUP_LONG_IN,
  // Wake sources
  input wire logic REALTIME_TIMER_IRQ_IN,
  input wire logic HALT_EXIT_IRQ_IN,
  input wire logic WAKE_RESET_IN,
  // Wake-up RC oscillator pin
  input wire logic WAKEUP_RC_CLK_IN,
  // Clock gating
  output logic MAIN_OSC_EN_OUT,
  output logic PERIPH_CLK_EN_OUT,
  output logic TIMER_CLK_EN_OUT,
  output logic WAKEUP_RC_EN_OUT,
  output logic CPU_RUN_OUT,
  // Events to the CPU
  output logic IMASK_CLEAR_OUT,
  output logic WAKEUP_IRQ_OUT,
  output logic WATCHDOG_RESET_OUT,
  output logic FETCH_RESET_VECTOR_OUT,
  output logic SERVICE_IRQ_OUT,
  output logic CAPTURE_INPUT_OUT,
  output logic [4:0] MODE_OUT
);

  hmawc_pkg::hmawc_state_t s_reg;
  hmawc_pkg::hmawc_state_t s_next;
  logic tmr_done;
  logic rc_tick;

  // ****************************************
  // Decoding helpers
  // ****************************************
  function automatic logic active_halt_ok(input logic tb_ie, input logic ovf_ie,
                                          input logic ck1, input logic ck0);
    active_halt_ok = tb_ie || (ovf_ie && !ck1 && ck0);
  endfunction

  function automatic logic [12:0] startup_len(input logic long_sel);
    startup_len = long_sel ? `HMAWC_STARTUP_LONG : `HMAWC_STARTUP_SHORT;
  endfunction

  // ****************************************
  // Wake-up delay timer
  // ****************************************
  assign rc_tick = s_reg.rc_sync2 && !s_reg.rc_prev;

  hmawc_awu_timer u_timer (
    .clk_in(CLK_SYS_IN),
    .rst_in(SYS_RST_IN),
    .start_in(s_reg.tmr_start),
    .stop_in(s_reg.mode != hmawc_pkg::HMAWC_AUTO_WAKEUP_HALT),
    .tick_in(rc_tick),
    .prescaler_in(s_reg.prescaler),
    .done_out(tmr_done)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic halt_seen;
    logic act_ok;
    logic csr_read;
    halt_seen = 1'b0;
    act_ok = 1'b0;
    csr_read = 1'b0;
    s_next = s_reg;
    s_next.rc_sync1 = WAKEUP_RC_CLK_IN;
    s_next.rc_sync2 = s_reg.rc_sync1;
    s_next.rc_prev = s_reg.rc_sync2;
    s_next.tmr_start = 1'b0;
    s_next.imask_clear = 1'b0;
    s_next.wdg_rst = 1'b0;
    s_next.fetch_reset = 1'b0;
    s_next.service_irq = 1'b0;
    s_next.rdata = 8'h00;

    // Register port; the read answer stands only in the following cycle.
    csr_read = RD_IN && (ADDR_IN == `HMAWC_OFS_CTRL_STATUS);
    if (RD_IN && (ADDR_IN == `HMAWC_OFS_PRESCALER)) begin
      s_next.rdata = s_reg.prescaler;
    end
    if (csr_read) begin
      s_next.rdata[`HMAWC_BIT_WAKE_EN] = s_reg.wake_en;
      s_next.rdata[`HMAWC_BIT_MEASURE] = s_reg.measure;
      s_next.rdata[`HMAWC_BIT_FLAG] = s_reg.flag;
      s_next.flag = 1'b0;
    end
    if (WR_IN && (ADDR_IN == `HMAWC_OFS_PRESCALER) && (WDATA_IN != 8'h00)) begin
      // A zero divisor is dropped and the old value kept.
      s_next.prescaler = WDATA_IN;
    end
    if (WR_IN && (ADDR_IN == `HMAWC_OFS_CTRL_STATUS)) begin
      // The flag bit is not writable.
      s_next.wake_en = WDATA_IN[`HMAWC_BIT_WAKE_EN];
      s_next.measure = WDATA_IN[`HMAWC_BIT_MEASURE];
    end

    // Expiry wins over a clearing read in the same cycle.
    if (tmr_done && (s_reg.mode == hmawc_pkg::HMAWC_AUTO_WAKEUP_HALT)) begin
      s_next.flag = 1'b1;
    end

    halt_seen = OPCODE_VALID_IN && (OPCODE_IN == `HMAWC_HALT_OPCODE);
    act_ok = active_halt_ok(TIMEBASE_IRQ_ENABLE_IN, OVERFLOW_IRQ_ENABLE_IN,
                            TIMER_CLOCK_SELECT_HIGH_IN, TIMER_CLOCK_SELECT_LOW_IN);

    case (s_reg.mode)
      hmawc_pkg::HMAWC_RUN: begin
        if (halt_seen) begin
          if (WATCHDOG_ACTIVE_IN && !act_ok && !WATCHDOG_IN_HALT_OPTION_IN) begin
            // Watchdog in halt not allowed: reset instead.
            s_next.wdg_rst = 1'b1;
          end else if (s_reg.wake_en) begin
            s_next.mode = hmawc_pkg::HMAWC_AUTO_WAKEUP_HALT;
            s_next.tmr_start = 1'b1;
            s_next.imask_clear = 1'b1;
          end else if (act_ok) begin
            s_next.mode = hmawc_pkg::HMAWC_ACTIVE_HALT;
            s_next.imask_clear = 1'b1;
          end else begin
            s_next.mode = hmawc_pkg::HMAWC_HALT;
            s_next.imask_clear = 1'b1;
          end
        end
      end
      hmawc_pkg::HMAWC_ACTIVE_HALT: begin
        if (WAKE_RESET_IN) begin
          s_next.mode = hmawc_pkg::HMAWC_STARTUP;
          s_next.exit_by_reset = 1'b1;
          s_next.startup_cnt = startup_len(STARTUP_LONG_IN) - 13'h0001;
        end else if (REALTIME_TIMER_IRQ_IN || HALT_EXIT_IRQ_IN) begin
          s_next.mode = hmawc_pkg::HMAWC_RUN;
          s_next.service_irq = 1'b1;
        end
      end
      hmawc_pkg::HMAWC_HALT,
      hmawc_pkg::HMAWC_AUTO_WAKEUP_HALT: begin
        // The oscillator restarts at once and the start-up delay follows.
        if (WAKE_RESET_IN || HALT_EXIT_IRQ_IN || s_reg.flag) begin
          s_next.mode = hmawc_pkg::HMAWC_STARTUP;
          s_next.exit_by_reset = WAKE_RESET_IN;
          s_next.startup_cnt = startup_len(STARTUP_LONG_IN) - 13'h0001;
        end
      end
      hmawc_pkg::HMAWC_STARTUP: begin
        if (s_reg.startup_cnt == 13'h0000) begin
          s_next.mode = hmawc_pkg::HMAWC_RUN;
          s_next.fetch_reset = s_reg.exit_by_reset;
          s_next.service_irq = !s_reg.exit_by_reset;
          s_next.exit_by_reset = 1'b0;
        end else begin
          s_next.startup_cnt = s_reg.startup_cnt - 13'h0001;
        end
      end
      default: begin
        s_next.mode = hmawc_pkg::HMAWC_RUN;
      end
    endcase

    // Gating follows the mode being entered so the outputs stay registered.
    s_next.osc_en = (s_next.mode == hmawc_pkg::HMAWC_RUN) ||
                    (s_next.mode == hmawc_pkg::HMAWC_ACTIVE_HALT) ||
                    (s_next.mode == hmawc_pkg::HMAWC_STARTUP);
    s_next.timer_en = (s_next.mode == hmawc_pkg::HMAWC_RUN) ||
                      (s_next.mode == hmawc_pkg::HMAWC_ACTIVE_HALT);
    s_next.periph_en = (s_next.mode == hmawc_pkg::HMAWC_RUN);
    s_next.cpu_run = (s_next.mode == hmawc_pkg::HMAWC_RUN);
    s_next.rc_en = (s_next.mode == hmawc_pkg::HMAWC_AUTO_WAKEUP_HALT) ||
                   (s_next.measure && (s_next.mode == hmawc_pkg::HMAWC_RUN));
    // The capture sees the oscillator only while measuring in run mode.
    s_next.capture = s_reg.measure && (s_reg.mode == hmawc_pkg::HMAWC_RUN) &&
                     s_reg.rc_sync2;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      s_reg <= '0;
      s_reg.mode <= hmawc_pkg::HMAWC_RUN;
      s_reg.prescaler <= `HMAWC_RST_PRESCALER;
      s_reg.osc_en <= 1'b1;
      s_reg.periph_en <= 1'b1;
      s_reg.timer_en <= 1'b1;
      s_reg.cpu_run <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign RDATA_OUT = s_reg.rdata;
  assign MAIN_OSC_EN_OUT = s_reg.osc_en;
  assign PERIPH_CLK_EN_OUT = s_reg.periph_en;
  assign TIMER_CLK_EN_OUT = s_reg.timer_en;
  assign WAKEUP_RC_EN_OUT = s_reg.rc_en;
  assign CPU_RUN_OUT = s_reg.cpu_run;
  assign IMASK_CLEAR_OUT = s_reg.imask_clear;
  assign WAKEUP_IRQ_OUT = s_reg.flag;
  assign WATCHDOG_RESET_OUT = s_reg.wdg_rst;
  assign FETCH_RESET_VECTOR_OUT = s_reg.fetch_reset;
  assign SERVICE_IRQ_OUT = s_reg.service_irq;
  assign CAPTURE_INPUT_OUT = s_reg.capture;
  assign MODE_OUT = s_reg.mode;

endmodule

//--- rtl/hmawc_params.svh
// Constants for the halt mode and auto wake-up controller.
// Assumes inclusion by bare name from the design files and the checker.
`ifndef HMAWC_PARAMS_SVH
`define HMAWC_PARAMS_SVH

// ****************************************
// Register offsets and fields
// ****************************************
`define HMAWC_ADDR_W 16
`define HMAWC_OFS_PRESCALER 16'h0049
`define HMAWC_OFS_CTRL_STATUS 16'h004A
`define HMAWC_BIT_WAKE_EN 0
`define HMAWC_BIT_MEASURE 1
`define HMAWC_BIT_FLAG 2
`define HMAWC_RST_PRESCALER 8'hFF
`define HMAWC_RST_CTRL_STATUS 8'h00

// ****************************************
// Instruction and timing
// ****************************************
`define HMAWC_HALT_OPCODE 8'h8E
`define HMAWC_STARTUP_SHORT 13'h0100
`define HMAWC_STARTUP_LONG 13'h1000
`define HMAWC_FIXED_DIV 7'h40
`define HMAWC_RC_START_TICKS 8'h04
`endif

//--- rtl/hmawc_pkg.sv
// Types shared by the halt mode and auto wake-up controller files.
// Assumes nothing of its surroundings.
package hmawc_pkg;

  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [4:0] {
    HMAWC_RUN = 5'h01,
    HMAWC_HALT = 5'h02,
    HMAWC_ACTIVE_HALT = 5'h04,
    HMAWC_AUTO_WAKEUP_HALT = 5'h08,
    HMAWC_STARTUP = 5'h10
  } hmawc_mode_t;

  // ****************************************
  // Wake-up timer state
  // ****************************************
  typedef struct packed {
    logic running;
    logic [7:0] start_cnt;
    logic [6:0] fix_cnt;
    logic [7:0] pre_cnt;
    logic done;
  } hmawc_tmr_t;

  // ****************************************
  // Controller state
  // ****************************************
  typedef struct packed {
    hmawc_mode_t mode;
    logic [7:0] prescaler;
    logic wake_en;
    logic measure;
    logic flag;
    logic [7:0] rdata;
    logic rc_sync1;
    logic rc_sync2;
    logic rc_prev;
    logic [12:0] startup_cnt;
    logic exit_by_reset;
    logic tmr_start;
    logic osc_en;
    logic periph_en;
    logic timer_en;
    logic rc_en;
    logic cpu_run;
    logic imask_clear;
    logic wdg_rst;
    logic fetch_reset;
    logic service_irq;
    logic capture;
  } hmawc_state_t;

endpackage

//--- rtl/hmawc_awu_timer.sv
// Wake-up delay timer: RC start time, fixed divide by 64, then prescaler.
// Assumes tick_in is a one-cycle enable per wake-up RC oscillator period.
`timescale 1ns/10ps
`include "hmawc_params.svh"

module hmawc_awu_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic tick_in,
  input wire logic [7:0] prescaler_in,
  // Result
  output logic done_out
);

  hmawc_pkg::hmawc_tmr_t s_reg;
  hmawc_pkg::hmawc_tmr_t s_next;

  // ****************************************
  // Counting
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (start_in) begin
      s_next.running = 1'b1;
      s_next.start_cnt = `HMAWC_RC_START_TICKS;
      s_next.fix_cnt = 7'h00;
      s_next.pre_cnt = 8'h00;
    end else if (stop_in) begin
      s_next.running = 1'b0;
    end else if (s_reg.running && tick_in) begin
      // The start time of the RC oscillator is spent before any division.
      if (s_reg.start_cnt != 8'h00) begin
        s_next.start_cnt = s_reg.start_cnt - 8'h01;
      end else if (s_reg.fix_cnt != `HMAWC_FIXED_DIV - 7'h01) begin
        s_next.fix_cnt = s_reg.fix_cnt + 7'h01;
      end else begin
        s_next.fix_cnt = 7'h00;
        // A prescaler of zero is treated like one, so the timer always ends.
        if (s_reg.pre_cnt + 8'h01 >= prescaler_in) begin
          s_next.running = 1'b0;
          s_next.done = 1'b1;
        end else begin
          s_next.pre_cnt = s_reg.pre_cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign done_out = s_reg.done;

endmodule

//--- tb/hmawc_properties.sv
// Concurrent checks on the ports of the halt sequencer top.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
`include "hmawc_params.svh"

module hmawc_checker (
  // Clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic SYS_RST_IN,
  // Requests
  input wire logic [`HMAWC_ADDR_W-1:0] ADDR_IN,
  input wire logic RD_IN,
  input wire logic OPCODE_VALID_IN,
  input wire logic [7:0] OPCODE_IN,
  input wire logic TIMEBASE_IRQ_ENABLE_IN,
  input wire logic OVERFLOW_IRQ_ENABLE_IN,
  input wire logic TIMER_CLOCK_SELECT_HIGH_IN,
  input wire logic TIMER_CLOCK_SELECT_LOW_IN,
  input wire logic WATCHDOG_ACTIVE_IN,
  input wire logic WATCHDOG_IN_HALT_OPTION_IN,
  input wire logic STARTUP_LONG_IN,
  input wire logic REALTIME_TIMER_IRQ_IN,
  input wire logic WAKE_RESET_IN,
  // Results
  input wire logic MAIN_OSC_EN_OUT,
  input wire logic TIMER_CLK_EN_OUT,
  input wire logic WAKEUP_RC_EN_OUT,
  input wire logic CPU_RUN_OUT,
  input wire logic IMASK_CLEAR_OUT,
  input wire logic WAKEUP_IRQ_OUT,
  input wire logic WATCHDOG_RESET_OUT,
  input wire logic SERVICE_IRQ_OUT,
  input wire logic [4:0] MODE_OUT
);
  // ********
  // Helpers
  // ********
  logic [12:0] cnt_reg;
  logic [12:0] cnt_next;
  wire [4:0] m = MODE_OUT;
  wire run = m == 5'h01;
  wire hop = run && OPCODE_VALID_IN && OPCODE_IN == `HMAWC_HALT_OPCODE;
  wire act = TIMEBASE_IRQ_ENABLE_IN ||
    (OVERFLOW_IRQ_ENABLE_IN && !TIMER_CLOCK_SELECT_HIGH_IN && TIMER_CLOCK_SELECT_LOW_IN);
  wire wdr = WATCHDOG_ACTIVE_IN && !WATCHDOG_IN_HALT_OPTION_IN && !act;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Startup length is counted here because a repetition of 4096 would not unroll.
  always_comb cnt_next = (m == 5'h10) ? cnt_reg + 13'h0001 : 13'h0000;
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      cnt_reg <= 13'h0000;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  // ********
  // Checks
  // ********
  AST_HALT_ENTRY: assert property (hop && !wdr |=> !run && IMASK_CLEAR_OUT)
    else $error("halt entry wrong");
  AST_NON_HALT: assert property (run && OPCODE_VALID_IN && OPCODE_IN != 8'h8E |=> run)
    else $error("other opcode left run");
  AST_ACTIVE_SEL: assert property (hop && act |=>
    (m == 5'h04 || m == 5'h08) && !WATCHDOG_RESET_OUT) else $error("active halt select");
  AST_WDG_OPTION: assert property (hop && wdr |=> WATCHDOG_RESET_OUT && run)
    else $error("watchdog reset missing");
  AST_ACTIVE_GATE: assert property (m == 5'h04 |->
    MAIN_OSC_EN_OUT && TIMER_CLK_EN_OUT && !CPU_RUN_OUT) else $error("active halt gating");
  AST_AWU_GATE: assert property (m == 5'h08 |-> WAKEUP_RC_EN_OUT && !MAIN_OSC_EN_OUT)
    else $error("auto wake-up gating");
  AST_ACTIVE_IRQ: assert property (m == 5'h04 && REALTIME_TIMER_IRQ_IN && !WAKE_RESET_IN |=>
    run && SERVICE_IRQ_OUT) else $error("active halt irq exit");
  AST_STARTUP: assert property ($fell(m == 5'h10) && !$past(SYS_RST_IN) |->
    cnt_reg == (STARTUP_LONG_IN ? 13'h1000 : 13'h0100)) else $error("startup length");
  AST_FLAG_WAKE: assert property ($rose(WAKEUP_IRQ_OUT) && m == 5'h08 |=> m == 5'h10)
    else $error("flag did not wake");
  AST_READ_CLR: assert property (run && RD_IN && ADDR_IN == `HMAWC_OFS_CTRL_STATUS |=>
    !WAKEUP_IRQ_OUT) else $error("read did not clear flag");
endmodule

bind hmawc_top hmawc_checker chk_u (.*);

//--- tb/hmawc_cpu_model.sv
// Stand-in for the CPU core and the wake-up RC oscillator.
// Assumes the system clock and a one-cycle halt request from the bench.
`timescale 1ns/10ps

module hmawc_cpu_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic halt_req_in,
  input wire logic cpu_run_in,
  input wire logic rc_en_in,
  // Stimulus
  output logic opcode_valid_out,
  output logic [7:0] opcode_out,
  output logic rc_clk_out
);
  // ********
  // Core and oscillator
  // ********
  logic [7:0] pc_reg = 8'h00;
  logic [1:0] div_reg = 2'h0;
  // The core issues only while clocked; ordinary opcodes never carry the halt value.
  always @(posedge clk_in) begin
    pc_reg <= pc_reg + 8'h01;
    opcode_valid_out <= cpu_run_in && !rst_in;
    opcode_out <= halt_req_in ? 8'h8E : (pc_reg == 8'h8E ? 8'h9D : pc_reg);
  end
  // The oscillator stands still while disabled.
  always @(posedge clk_in) begin
    if (!rc_en_in) begin
      div_reg <= 2'h0;
      rc_clk_out <= 1'b0;
    end else begin
      div_reg <= div_reg + 2'h1;
      rc_clk_out <= div_reg[0] ? !rc_clk_out : rc_clk_out;
    end
  end
endmodule

//--- tb/halt_mode_auto_wakeup_control_tb_top.sv
// Self-checking bench for the halt sequencer.
// Assumes the design, the checker and the CPU model are compiled first.
`timescale 1ns/10ps

module halt_mode_auto_wakeup_control_tb_top;
  // ********
  // Signals
  // ********
  logic CLK_SYS_IN = 0, SYS_RST_IN = 1, WR_IN = 0, RD_IN = 0, TIMEBASE_IRQ_ENABLE_IN = 0;
  logic OVERFLOW_IRQ_ENABLE_IN = 0, TIMER_CLOCK_SELECT_HIGH_IN = 0, TIMER_CLOCK_SELECT_LOW_IN = 0;
  logic WATCHDOG_ACTIVE_IN = 0, WATCHDOG_IN_HALT_OPTION_IN = 0, STARTUP_LONG_IN = 0;
  logic REALTIME_TIMER_IRQ_IN = 0, HALT_EXIT_IRQ_IN = 0, WAKE_RESET_IN = 0, halt_req = 0;
  logic [15:0] ADDR_IN = 16'h0000;
  logic [7:0] WDATA_IN = 8'h00, RDATA_OUT, OPCODE_IN, p;
  logic OPCODE_VALID_IN, WAKEUP_RC_CLK_IN, MAIN_OSC_EN_OUT, PERIPH_CLK_EN_OUT, TIMER_CLK_EN_OUT;
  logic WAKEUP_RC_EN_OUT, CPU_RUN_OUT, IMASK_CLEAR_OUT, WAKEUP_IRQ_OUT, WATCHDOG_RESET_OUT;
  logic FETCH_RESET_VECTOR_OUT, SERVICE_IRQ_OUT, CAPTURE_INPUT_OUT, rd_seen = 0;
  logic [4:0] MODE_OUT;
  logic [7:0] exp_q[$];
  int n_mismatch = 0, comparisons = 0, n, i, seed = 32'h3495;

  always #4 CLK_SYS_IN = !CLK_SYS_IN;
  hmawc_top dut_u (.*);
  hmawc_cpu_model cpu_u (.clk_in(CLK_SYS_IN), .rst_in(SYS_RST_IN), .halt_req_in(halt_req),
    .cpu_run_in(CPU_RUN_OUT), .rc_en_in(WAKEUP_RC_EN_OUT), .opcode_valid_out(OPCODE_VALID_IN),
    .opcode_out(OPCODE_IN), .rc_clk_out(WAKEUP_RC_CLK_IN));

  // ********
  // Tasks
  // ********
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_SYS_IN);
    ADDR_IN <= a;
    WDATA_IN <= d;
    WR_IN <= 1'b1;
    @(posedge CLK_SYS_IN);
    WR_IN <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge CLK_SYS_IN);
    ADDR_IN <= a;
    RD_IN <= 1'b1;
    @(posedge CLK_SYS_IN);
    RD_IN <= 1'b0;
  endtask
  task halt;
    @(posedge CLK_SYS_IN);
    halt_req <= 1'b1;
    @(posedge CLK_SYS_IN);
    halt_req <= 1'b0;
  endtask
  task waitm(input logic [4:0] m, input int lim);
    for (n = 0; n < lim && MODE_OUT !== m; n++) @(posedge CLK_SYS_IN);
    chk(MODE_OUT, m);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  always @(posedge CLK_SYS_IN) rd_seen <= RD_IN;
  always @(negedge CLK_SYS_IN) begin
    if (rd_seen) chk(RDATA_OUT, exp_q.pop_front());
  end

  initial begin
    #400000;
    n_mismatch++;
    conclude;
  end

  // ********
  // Scenarios
  // ********
  initial begin
    repeat (12) @(posedge CLK_SYS_IN);
    SYS_RST_IN <= 1'b0;
    rd(16'h004A, 8'h00);
    rd(16'h0049, 8'hFF);
    rd(16'h0000, 8'h00);
    wr(16'h004A, 8'hFF);
    rd(16'h004A, 8'h03);
    wr(16'h004A, 8'h00);
    $display("registers done");
    WATCHDOG_ACTIVE_IN <= 1'b1;
    WATCHDOG_IN_HALT_OPTION_IN <= 1'b1;
    for (i = 0; i < 2; i++) begin
      STARTUP_LONG_IN <= i[0];
      halt();
      waitm(5'h02, 20);
      chk(IMASK_CLEAR_OUT, 1'b1);
      REALTIME_TIMER_IRQ_IN <= 1'b1;
      repeat (8) @(posedge CLK_SYS_IN);
      chk(MODE_OUT, 5'h02);
      REALTIME_TIMER_IRQ_IN <= 1'b0;
      HALT_EXIT_IRQ_IN <= 1'b1;
      waitm(5'h10, 4);
      HALT_EXIT_IRQ_IN <= 1'b0;
      waitm(5'h01, 5000);
      chk(n, i ? 4096 : 256);
      chk(SERVICE_IRQ_OUT, 1'b1);
    end
    $display("plain halt done");
    STARTUP_LONG_IN <= 1'b0;
    WATCHDOG_IN_HALT_OPTION_IN <= 1'b0;
    for (i = 0; i < 2; i++) begin
      TIMEBASE_IRQ_ENABLE_IN <= !i[0];
      OVERFLOW_IRQ_ENABLE_IN <= i[0];
      TIMER_CLOCK_SELECT_LOW_IN <= i[0];
      halt();
      waitm(5'h04, 20);
      chk({MAIN_OSC_EN_OUT, TIMER_CLK_EN_OUT, PERIPH_CLK_EN_OUT, CPU_RUN_OUT}, 4'hC);
      if (i == 0) begin
        REALTIME_TIMER_IRQ_IN <= 1'b1;
        waitm(5'h01, 4);
        chk(SERVICE_IRQ_OUT, 1'b1);
        REALTIME_TIMER_IRQ_IN <= 1'b0;
      end else begin
        WAKE_RESET_IN <= 1'b1;
        waitm(5'h10, 4);
        WAKE_RESET_IN <= 1'b0;
        waitm(5'h01, 300);
        chk(FETCH_RESET_VECTOR_OUT, 1'b1);
      end
    end
    $display("active halt done");
    TIMEBASE_IRQ_ENABLE_IN <= 1'b0;
    OVERFLOW_IRQ_ENABLE_IN <= 1'b0;
    halt();
    for (n = 0; n < 6 && WATCHDOG_RESET_OUT !== 1'b1; n++) @(posedge CLK_SYS_IN);
    chk({WATCHDOG_RESET_OUT, MODE_OUT}, 6'h21);
    $display("watchdog done");
    WATCHDOG_ACTIVE_IN <= 1'b0;
    p = 8'h01 + 8'($random(seed) & 1);
    wr(16'h0049, p);
    rd(16'h0049, p);
    wr(16'h004A, 8'h01);
    TIMEBASE_IRQ_ENABLE_IN <= 1'b1;
    halt();
    waitm(5'h08, 20);
    chk({MAIN_OSC_EN_OUT, WAKEUP_RC_EN_OUT}, 2'h1);
    for (n = 0; n < 2000 && WAKEUP_IRQ_OUT !== 1'b1; n++) @(posedge CLK_SYS_IN);
    chk(n >= 256 * p && n <= 256 * p + 40, 1'b1);
    waitm(5'h10, 4);
    waitm(5'h01, 300);
    chk(SERVICE_IRQ_OUT, 1'b1);
    rd(16'h004A, 8'h05);
    rd(16'h004A, 8'h01);
    wr(16'h004A, 8'h02);
    for (n = 0; n < 20 && CAPTURE_INPUT_OUT !== 1'b1; n++) @(posedge CLK_SYS_IN);
    chk({WAKEUP_RC_EN_OUT, CAPTURE_INPUT_OUT}, 2'h3);
    wr(16'h004A, 8'h00);
    wr(16'h0049, 8'h03);
    SYS_RST_IN <= 1'b1;
    repeat (2) @(posedge CLK_SYS_IN);
    SYS_RST_IN <= 1'b0;
    rd(16'h0049, 8'hFF);
    rd(16'h004A, 8'h00);
    chk(MODE_OUT, 5'h01);
    $display("auto wake-up done");
    repeat (4) @(posedge CLK_SYS_IN);
    conclude;
  end
endmodule
